/* hw/gwib_map.vh */
// Register map and constants for the pin, watchdog and power-init event bank
`ifndef GWIB_MAP_VH
`define GWIB_MAP_VH

// Register indices (byte address is four times the index)
`define GWIB_IDX_PIN_EDGE_STATUS_LOW 8'h52
`define GWIB_IDX_PIN_EDGE_MASK_LOW   8'h53
`define GWIB_IDX_MISC_EVENT_STATUS   8'h54
`define GWIB_IDX_MISC_EVENT_MASK     8'h55

// Byte addresses on the register bus
`define GWIB_ADDR_PIN_EDGE_STATUS_LOW 10'h148
`define GWIB_ADDR_PIN_EDGE_MASK_LOW   10'h14c
`define GWIB_ADDR_MISC_EVENT_STATUS   10'h150
`define GWIB_ADDR_MISC_EVENT_MASK     10'h154

// Widths
`define GWIB_AW 10
`define GWIB_DW 32
`define GWIB_RW 8

// Reset values
`define GWIB_MASK_RST   8'hff
`define GWIB_STATUS_RST 8'h00

// Field positions in the misc event registers
`define GWIB_BIT_PIN4_RISE  0
`define GWIB_BIT_PIN4_FALL  1
`define GWIB_BIT_PIN5_RISE  2
`define GWIB_BIT_PIN5_FALL  3
`define GWIB_BIT_WATCHDOG   4
`define GWIB_BIT_POWER_INIT 7

// Implemented bits
`define GWIB_MISC_VALID 8'h9f
`define GWIB_LOW_VALID  8'hff

`endif

/* hw/gwib_flag_reg.v */
// Write-one-to-clear status flags with set priority over clear
`timescale 1ns/1ps
`default_nettype none
`include "gwib_map.vh"

module gwib_flag_reg (
  // Clock and reset
  input  wire                 clk_in,
  input  wire                 rst_in,
  // Event and clear strobes, implemented-bit mask
  input  wire [`GWIB_RW-1:0]  set_in,
  input  wire [`GWIB_RW-1:0]  clr_in,
  input  wire [`GWIB_RW-1:0]  valid_in,
  // Flags
  output reg  [`GWIB_RW-1:0]  flag_q_out
);

  wire [`GWIB_RW-1:0] flag_d;

  // Set beats clear; zero bits keep their value
  assign flag_d = ((flag_q_out & ~clr_in) | set_in) & valid_in;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_q_out <= `GWIB_STATUS_RST;
    end else begin
      flag_q_out <= flag_d;
    end
  end

endmodule // gwib_flag_reg
`default_nettype wire

/* hw/gwib_irq_bank.v */
// Event status and mask bank with APB access and host interrupt
`timescale 1ns/1ps
`default_nettype none
`include "gwib_map.vh"

module gwib_irq_bank (
  // Clock and resets
  input  wire                 clk_in,
  input  wire                 rst_in,
  input  wire                 full_rst_in,
  // Events, one-cycle pulses from the detectors; power-init is a level input
  input  wire [3:0]           pin_rise_in,
  input  wire [3:0]           pin_fall_in,
  input  wire [1:0]           pin_hi_rise_in,
  input  wire [1:0]           pin_hi_fall_in,
  input  wire                 watchdog_event_in,
  input  wire                 power_init_reset_input_in,
  // APB slave
  input  wire                 psel_in,
  input  wire                 penable_in,
  input  wire                 pwrite_in,
  input  wire [`GWIB_AW-1:0]  paddr_in,
  input  wire [`GWIB_DW-1:0]  pwdata_in,
  output reg  [`GWIB_DW-1:0]  prdata_out,
  output reg                  pready_out,
  output reg                  pslverr_out,
  // Host interrupt
  output reg                  host_irq_out
);

  reg  [`GWIB_RW-1:0] pin_edge_mask_low_q;
  reg  [`GWIB_RW-1:0] misc_event_mask_q;
  reg                 power_init_prev_q;
  wire [`GWIB_RW-1:0] low_flags;
  wire [`GWIB_RW-1:0] misc_flags;
  wire [`GWIB_RW-1:0] low_set;
  wire [`GWIB_RW-1:0] misc_set;
  wire [`GWIB_RW-1:0] low_clr;
  wire [`GWIB_RW-1:0] misc_clr;
  wire                setup;
  wire                wr;
  wire                power_init_event;
  reg  [`GWIB_DW-1:0] rd_d;
  reg                 hit_d;

  // Interleave rise and fall into rise-even, fall-odd bit order
  function [`GWIB_RW-1:0] pack_edges;
    input [3:0] rise;
    input [3:0] fall;
    integer i;
    begin
      pack_edges = `GWIB_STATUS_RST;
      for (i = 0; i < 4; i = i + 1) begin
        pack_edges[2*i]   = rise[i];
        pack_edges[2*i+1] = fall[i];
      end
    end
  endfunction

  // Decode a write-one-to-clear strobe for one register
  function [`GWIB_RW-1:0] clr_for;
    input                sel;
    input [`GWIB_RW-1:0] data;
    begin
      clr_for = sel ? data : `GWIB_STATUS_RST;
    end
  endfunction

  // APB: one wait-free access phase; setup samples the request
  assign setup = psel_in & ~penable_in;
  assign wr    = psel_in & penable_in & pwrite_in;

  // Power-init input is a level; it flags on going high
  assign power_init_event = power_init_reset_input_in & ~power_init_prev_q;

  assign low_set = pack_edges(pin_rise_in, pin_fall_in);

  assign misc_set = {power_init_event,
                     2'b00,
                     watchdog_event_in,
                     pin_hi_fall_in[1], pin_hi_rise_in[1],
                     pin_hi_fall_in[0], pin_hi_rise_in[0]};

  assign low_clr = clr_for(wr &
    (paddr_in == `GWIB_ADDR_PIN_EDGE_STATUS_LOW),
    pwdata_in[`GWIB_RW-1:0]);
  assign misc_clr = clr_for(wr &
    (paddr_in == `GWIB_ADDR_MISC_EVENT_STATUS),
    pwdata_in[`GWIB_RW-1:0]);

  // Flags belong to the full reset domain
  gwib_flag_reg u_low_flags (
    .clk_in     (clk_in),
    .rst_in     (full_rst_in),
    .set_in     (low_set),
    .clr_in     (low_clr),
    .valid_in   (`GWIB_LOW_VALID),
    .flag_q_out (low_flags)
  );

  gwib_flag_reg u_misc_flags (
    .clk_in     (clk_in),
    .rst_in     (full_rst_in),
    .set_in     (misc_set),
    .clr_in     (misc_clr),
    .valid_in   (`GWIB_MISC_VALID),
    .flag_q_out (misc_flags)
  );

  // Edge memory of the power-init level
  always @(posedge clk_in or posedge full_rst_in) begin
    if (full_rst_in) begin
      power_init_prev_q <= 1'b0;
    end else begin
      power_init_prev_q <= power_init_reset_input_in;
    end
  end

  // Mask registers in the general reset domain
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_edge_mask_low_q <= `GWIB_MASK_RST;
      misc_event_mask_q   <= `GWIB_MASK_RST;
    end else if (wr) begin
      if (paddr_in == `GWIB_ADDR_PIN_EDGE_MASK_LOW) begin
        pin_edge_mask_low_q <= pwdata_in[`GWIB_RW-1:0];
      end
      if (paddr_in == `GWIB_ADDR_MISC_EVENT_MASK) begin
        misc_event_mask_q <= pwdata_in[`GWIB_RW-1:0];
      end
    end
  end

  // Read mux; reserved status bits and upper lanes read zero, mask bits 5 and 6 read as written
  always @* begin
    rd_d  = {`GWIB_DW{1'b0}};
    hit_d = 1'b1;
    case (paddr_in)
      `GWIB_ADDR_PIN_EDGE_STATUS_LOW: begin
        rd_d[`GWIB_RW-1:0] = low_flags;
      end
      `GWIB_ADDR_PIN_EDGE_MASK_LOW: begin
        rd_d[`GWIB_RW-1:0] = pin_edge_mask_low_q;
      end
      `GWIB_ADDR_MISC_EVENT_STATUS: begin
        rd_d[`GWIB_RW-1:0] = misc_flags;
      end
      `GWIB_ADDR_MISC_EVENT_MASK: begin
        rd_d[`GWIB_RW-1:0] = misc_event_mask_q;
      end
      default: begin
        hit_d = 1'b0;
      end
    endcase
  end

  // Bus answer registered in the setup cycle, ready in the access cycle
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_out  <= {`GWIB_DW{1'b0}};
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= setup;
      pslverr_out <= setup & ~hit_d;
      if (setup & ~pwrite_in) begin
        prdata_out <= rd_d;
      end
    end
  end

  // Interrupt from unmasked flags only
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      host_irq_out <= 1'b0;
    end else begin
      host_irq_out <= |(low_flags & ~pin_edge_mask_low_q) |
                      |(misc_flags & ~misc_event_mask_q &
                        `GWIB_MISC_VALID);
    end
  end

endmodule // gwib_irq_bank
`default_nettype wire

/* tb/gwib_irq_bank_sva.sv */
// Checker for the event bank register port and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "gwib_map.vh"
module gwib_irq_bank_sva (
  // Clock and resets
  input wire logic                clk_in,
  input wire logic                rst_in,
  input wire logic                full_rst_in,
  // Inputs
  input wire logic                watchdog_event_in,
  input wire logic                psel_in,
  input wire logic                penable_in,
  input wire logic                pwrite_in,
  input wire logic [`GWIB_AW-1:0] paddr_in,
  // Outputs
  input wire logic [`GWIB_DW-1:0] prdata_out,
  input wire logic                pready_out,
  input wire logic                pslverr_out,
  input wire logic                host_irq_out
);
  wire logic acc = psel_in && penable_in;
  wire logic wr = acc && pwrite_in;
  wire logic hit = paddr_in inside {10'h148, 10'h14c, 10'h150, 10'h154};
  wire logic rd_misc = acc && !pwrite_in && paddr_in == 10'h150;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in || full_rst_in);
  a_ready_access: assert property (acc |-> pready_out)
    else $error("no ready in access");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready too long");
  a_err_unmapped: assert property (acc && !hit |-> pslverr_out)
    else $error("no error on hole");
  a_err_mapped: assert property (acc && hit |-> !pslverr_out)
    else $error("error on register");
  a_rsvd_zero: assert property (rd_misc |->
    prdata_out[31:8] == 0 && prdata_out[6:5] == 0)
    else $error("reserved bits set");
  a_wdog_flag: assert property (watchdog_event_in ##3 rd_misc |-> prdata_out[4])
    else $error("watchdog flag lost");
  a_irq_fall: assert property ($fell(host_irq_out) |-> $past(wr, 2))
    else $error("irq fell alone");
  a_rdata_hold: assert property (!(psel_in && !penable_in && !pwrite_in)
    |=> $stable(prdata_out))
    else $error("read data moved");
  cover property (rd_misc && prdata_out[4]);
  cover property ($rose(host_irq_out));
  cover property (acc && pslverr_out);
endmodule // gwib_irq_bank_sva
bind gwib_irq_bank gwib_irq_bank_sva u_sva (.clk_in(clk_in), .rst_in(rst_in),
  .full_rst_in(full_rst_in), .watchdog_event_in(watchdog_event_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .host_irq_out(host_irq_out));
`default_nettype wire

/* tb/gwib_host_model.sv */
// Host interrupt input that counts interrupt requests
`timescale 1ns/1ps
`default_nettype none
module gwib_host_model (
  // Clock, reset and interrupt line
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        irq_in,
  // Requests seen
  output logic [7:0]      count_out
);
  logic seen_q;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      seen_q <= 1'b0;
      count_out <= 8'h00;
    end else begin
      seen_q <= irq_in;
      if (irq_in && !seen_q) count_out <= count_out + 8'h01;
    end
  end
endmodule // gwib_host_model
`default_nettype wire

/* tb/tb_top.sv */
// Testbench for the event status and mask bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [9:0] SL = 10'h148, ML = 10'h14c, SM = 10'h150, MM = 10'h154;
  logic clk_in, rst_in, full_rst_in, wdog, pwr_in, irq, perr;
  logic psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [3:0] rise_v, fall_v;
  logic [1:0] hrise_v, hfall_v;
  logic [9:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rv;
  logic [7:0] cnt;
  int n_errors = 0, num_checks = 0;
  gwib_irq_bank uut (.clk_in(clk_in), .rst_in(rst_in), .full_rst_in(full_rst_in),
    .pin_rise_in(rise_v), .pin_fall_in(fall_v), .pin_hi_rise_in(hrise_v),
    .pin_hi_fall_in(hfall_v), .watchdog_event_in(wdog),
    .power_init_reset_input_in(pwr_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .host_irq_out(irq));
  gwib_host_model host (.clk_in(clk_in), .rst_in(rst_in), .irq_in(irq),
    .count_out(cnt));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int i;
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_in);
      i++;
    end while (pready_out !== 1'b1 && i < 16);
    if (i >= 16) begin
      n_errors++;
      stop_test;
    end
    rv = prdata_out;
    perr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task rd(input logic [9:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(rv, {24'h0, e});
  endtask
  task ev(input logic [12:0] v);
    {rise_v, fall_v, hrise_v, hfall_v, wdog} <= v;
    @(posedge clk_in);
    {rise_v, fall_v, hrise_v, hfall_v, wdog} <= 13'h0;
    @(posedge clk_in);
  endtask
  initial begin
    rst_in = 1'b1;
    full_rst_in = 1'b1;
    {wdog, pwr_in, rise_v, fall_v, hrise_v, hfall_v, psel_in, penable_in,
     pwrite_in, paddr_in, pwdata_in} = '0;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    full_rst_in <= 1'b0;
    @(posedge clk_in);
    rd(ML, 8'hff);
    rd(MM, 8'hff);
    rd(SM, 8'h00);
    $display("reset test done");
    ev(13'h1);
    chk(irq, 32'h0);
    rd(SM, 8'h10);
    apb(1'b1, MM, 32'hef);
    repeat (2) @(posedge clk_in);
    chk(irq, 32'h1);
    apb(1'b1, SM, 32'hffffff6f);
    rd(SM, 8'h10);
    apb(1'b1, SM, 32'h10);
    @(posedge clk_in);
    chk(irq, 32'h0);
    pwr_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(SM, 8'h80);
    apb(1'b1, SM, 32'h80);
    rd(SM, 8'h00);
    pwr_in <= 1'b0;
    ev(13'h1e);
    rd(SM, 8'h0f);
    apb(1'b1, SM, 32'hff);
    $display("misc test done");
    ev(13'h1fe0);
    chk(irq, 32'h0);
    rd(SL, 8'hff);
    apb(1'b1, ML, 32'h55);
    rd(ML, 8'h55);
    chk(irq, 32'h1);
    apb(1'b1, SL, 32'haa);
    rd(SL, 8'h55);
    chk(irq, 32'h0);
    apb(1'b0, 10'h158, 32'h0);
    chk({31'h0, perr}, 32'h1);
    chk(cnt, 32'h2);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(SL, 8'h55);
    rd(ML, 8'hff);
    full_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    full_rst_in <= 1'b0;
    @(posedge clk_in);
    rd(SL, 8'h00);
    $display("low pin and reset test done");
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
